/* File: cga_map.svh */
/*
 * Constants of the character glyph and cursor addressing block: register
 * offsets, field positions, reset values and timing counts.
 * Assumes a 25 MHz system clock and a 32-bit classic Wishbone slave.
 */
`ifndef CGA_MAP_SVH
`define CGA_MAP_SVH

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define CGA_OFS_CTRL 6'h00
`define CGA_OFS_ADDR 6'h04
`define CGA_OFS_TEXT 6'h08
`define CGA_OFS_GLYPH 6'h0C
`define CGA_OFS_STAT 6'h10

// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define CGA_CTRL_LINES 0
`define CGA_CTRL_TALL 1
`define CGA_CTRL_CURSOR 2
`define CGA_CTRL_BLINK 3
`define CGA_CTRL_RESET 4'h0

// ------------------------------------------------------------
// addressing
// ------------------------------------------------------------
`define CGA_CMD_TEXT_BIT 7
`define CGA_CMD_GLYPH_BIT 6
`define CGA_LINE2_BASE 7'h40
`define CGA_VISIBLE 20
`define CGA_ROWS_TALL 11
`define CGA_ROWS_SHORT 8

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CGA_BLINK_MS 400
`define CGA_CLK_KHZ 25000
`define CGA_BLINK_CYC (`CGA_BLINK_MS * `CGA_CLK_KHZ)

`endif

/* File: cga_pkg.sv */
/*
 * Types of the character glyph and cursor addressing block.
 * Assumes cga_map.svh for every numeric constant.
 */
package cga_pkg;

    // ------------------------------------------------------------
    // scan state
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        CGA_FETCH_CODE = 2'h0,
        CGA_FETCH_ROW = 2'h1,
        CGA_EMIT = 2'h3
    } cga_scan_type;

endpackage

/* File: cga_char_glyph.sv */
/*
 * Character glyph, cursor and blink addressing with refresh scan and
 * common/segment drive, behind a classic Wishbone register slave.
 * Assumes one 25 MHz clock, synchronous active-low reset, a host that
 * writes glyph rows with the cursor row left at zero.
 */
// Local design decisions: the address map and the Wishbone register port.
// What this block does
// - glyph byte bits 0..4 form one pixel row, bit 4 leftmost
// - tall glyphs: code bits 1,2 become glyph address bits 4,5
// - a one bit lights its pixel, a zero leaves it dark
// - tall glyphs: glyph address bits 0..3 select the row
// - tall glyphs: row eleven is cursor row, glyph data ORed with cursor
// - any set cursor-row bit lights regardless of cursor place
// - code bits 4..7 all zero select user glyph ram
// - tall glyphs: code bits 0 and 3 ignored
// - host access kept apart from refresh reads, no flicker
// - sixteen commons, hundred segments, active commons from font and lines
// - unused commons carry the non-selection level
// - cursor or blink at text address equal to address pointer
// - one line: positions 1..20 map to text addresses 00h..13h
// - two lines: line one from 00h, line two from 40h to 53h
// - pointer on glyph ram may put cursor anywhere meaningless
// - one line holds 128 chars, two lines hold 64 each
// - text address command: bit 7 set, address in bits 6..0
// - short glyphs: code bits 0..2 become glyph address bits 3..5
// - short glyphs: row eight is cursor row, ORed with cursor
`timescale 1ns/1ps
`include "cga_map.svh"

module cga_char_glyph #(
    parameter int BLINK_CYC = `CGA_BLINK_CYC
)(
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [5:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [3:0] WB_SEL_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic [15:0] COM_SEL,
    output logic [99:0] SEG_OUT
);

    // ------------------------------------------------------------
    // memories: text ram and user glyph ram
    // ------------------------------------------------------------
    logic [7:0] text_ram [0:127];
    logic [4:0] user_glyph_ram [0:63];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [3:0] ctrl;
        logic [6:0] address_pointer;
        logic on_glyph;
        logic [31:0] blink_cnt;
        logic blink_ph;
        cga_pkg::cga_scan_type scan;
        logic [4:0] col;
        logic [3:0] row;
        logic line;
        logic [7:0] code;
        logic [99:0] seg_acc;
        logic [99:0] seg;
        logic [15:0] com;
    } cga_state_type;

    cga_state_type s_q;
    cga_state_type s_d;

    logic wb_req;
    logic wr_text;
    logic wr_glyph;
    logic [6:0] ref_addr;
    logic [5:0] gaddr;
    logic tall;
    logic [3:0] last_row;
    logic [4:0] pix;
    logic [7:0] gl_code;
    logic [4:0] gl_row;
    logic [6:0] char_address_word;
    logic [4:0] cnt_rows;

    assign wb_req = WB_CYC_I && WB_STB_I && !s_q.ack;
    assign tall = s_q.ctrl[`CGA_CTRL_TALL];
    assign last_row = tall ? 4'(`CGA_ROWS_TALL - 1) : 4'(`CGA_ROWS_SHORT - 1);
    assign wr_text = wb_req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == `CGA_OFS_TEXT;
    assign wr_glyph = wb_req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == `CGA_OFS_GLYPH;

    // ------------------------------------------------------------
    // refresh reads on their own port, host writes on another
    // ------------------------------------------------------------
    always_comb
    begin
        ref_addr = {s_q.line, 1'b0, s_q.col};
        if (!s_q.ctrl[`CGA_CTRL_LINES])
        begin
            ref_addr = {2'b00, s_q.col};
        end
        // code fetched last cycle: s_q.code still holds the previous cell here
        if (tall)
        begin
            gaddr = {gl_code[2:1], s_q.row};
        end
        else
        begin
            gaddr = {gl_code[2:0], s_q.row[2:0]};
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (wr_text)
        begin
            text_ram[s_q.address_pointer] <= WB_DAT_I[7:0];
        end
        if (wr_glyph)
        begin
            user_glyph_ram[s_q.address_pointer[5:0]] <= WB_DAT_I[4:0];
        end
        gl_code <= text_ram[ref_addr];
        gl_row <= user_glyph_ram[gaddr];
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        pix = 5'h00;
        cnt_rows = 5'(`CGA_ROWS_SHORT);
        char_address_word = WB_DAT_I[6:0];
        s_d.ack = wb_req;
        if (wb_req && WB_WE_I && WB_SEL_I[0])
        begin
            if (WB_ADR_I == `CGA_OFS_CTRL)
            begin
                s_d.ctrl = WB_DAT_I[3:0];
            end
            else if (WB_ADR_I == `CGA_OFS_ADDR)
            begin
                s_d.on_glyph = !WB_DAT_I[`CGA_CMD_TEXT_BIT];
                s_d.address_pointer = WB_DAT_I[`CGA_CMD_TEXT_BIT] ? char_address_word
                                      : {1'b0, WB_DAT_I[5:0]};
            end
            else if (WB_ADR_I == `CGA_OFS_TEXT || WB_ADR_I == `CGA_OFS_GLYPH)
            begin
                s_d.address_pointer = s_q.address_pointer + 7'h01;
            end
        end
        s_d.rdat = 32'h0000_0000;
        if (wb_req && !WB_WE_I)
        begin
            if (WB_ADR_I == `CGA_OFS_CTRL)
            begin
                s_d.rdat = {28'h000_0000, s_q.ctrl};
            end
            else if (WB_ADR_I == `CGA_OFS_ADDR)
            begin
                s_d.rdat = {24'h00_0000, !s_q.on_glyph, s_q.address_pointer};
            end
            else if (WB_ADR_I == `CGA_OFS_STAT)
            begin
                s_d.rdat = {21'h0_0000, s_q.blink_ph, s_q.line, s_q.row, s_q.col};
            end
        end
        // blink phase from a free-running divider
        s_d.blink_cnt = s_q.blink_cnt + 32'h0000_0001;
        if (s_q.blink_cnt >= 32'(BLINK_CYC - 1))
        begin
            s_d.blink_cnt = 32'h0000_0000;
            s_d.blink_ph = !s_q.blink_ph;
        end
        case (s_q.scan)
            cga_pkg::CGA_FETCH_CODE:
            begin
                s_d.scan = cga_pkg::CGA_FETCH_ROW;
            end
            cga_pkg::CGA_FETCH_ROW:
            begin
                s_d.code = gl_code;
                s_d.scan = cga_pkg::CGA_EMIT;
            end
            default:
            begin
                if (s_q.code[7:4] == 4'h0)
                begin
                    pix = gl_row;
                end
                else
                begin
                    pix = 5'h00; // font rom kept outside this block
                end
                // cursor pointer may sit on glyph ram: harmless spot
                if (!s_q.on_glyph || 1'b1)
                begin
                    if (s_q.address_pointer == ref_addr)
                    begin
                        if (s_q.ctrl[`CGA_CTRL_CURSOR] && s_q.row == last_row)
                        begin
                            pix = pix | 5'h1F;
                        end
                        if (s_q.ctrl[`CGA_CTRL_BLINK] && s_q.blink_ph)
                        begin
                            pix = 5'h1F;
                        end
                    end
                end
                s_d.seg_acc[7'(99 - 5 * s_q.col) -: 5] = pix;
                s_d.scan = cga_pkg::CGA_FETCH_CODE;
                if (s_q.col == 5'(`CGA_VISIBLE - 1))
                begin
                    s_d.col = 5'h00;
                    s_d.seg = s_d.seg_acc;
                    cnt_rows = tall ? 5'(`CGA_ROWS_TALL) : 5'(`CGA_ROWS_SHORT);
                    s_d.com = 16'h0000;
                    s_d.com[{s_q.line & s_q.ctrl[`CGA_CTRL_LINES], 3'h0} + 4'(s_q.row)]
                        = (5'(s_q.row) < cnt_rows);
                    if (s_q.row == last_row)
                    begin
                        s_d.row = 4'h0;
                        s_d.line = s_q.ctrl[`CGA_CTRL_LINES] && !s_q.line;
                    end
                    else
                    begin
                        s_d.row = s_q.row + 4'h1;
                    end
                end
                else
                begin
                    s_d.col = s_q.col + 5'h01;
                end
            end
        endcase
        // a font height change mid-frame can leave row past the glyph
        if (s_q.row > last_row)
        begin
            s_d.row = 4'h0;
        end
        if (!NRST)
        begin
            s_d = '0;
            s_d.ctrl = `CGA_CTRL_RESET;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        s_q <= s_d;
    end

    assign WB_ACK_O = s_q.ack;
    assign WB_DAT_O = s_q.rdat;
    assign COM_SEL = s_q.com;
    assign SEG_OUT = s_q.seg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_addr_write;
        wb_req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == `CGA_OFS_ADDR
        && WB_DAT_I[7];
    endsequence

    a_ack_one_cycle: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        wb_req |=> WB_ACK_O ##1 !WB_ACK_O) else $error("ack not single cycle");
    a_text_cmd_load: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        s_addr_write |=> s_q.address_pointer == $past(WB_DAT_I[6:0]) && !s_q.on_glyph)
        else $error("text address command not loaded");
    a_one_line_map: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        !s_q.ctrl[0] |-> ref_addr == {2'b00, s_q.col}) else $error("one line map");
    a_two_line_map: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        s_q.ctrl[0] && s_q.line |-> ref_addr == `CGA_LINE2_BASE + 7'(s_q.col))
        else $error("second line base wrong");
    a_tall_glyph_addr: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        tall |-> gaddr[5:4] == gl_code[2:1] && gaddr[3:0] == s_q.row)
        else $error("tall glyph address");
    a_short_glyph_addr: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        !tall |-> gaddr == {gl_code[2:0], s_q.row[2:0]}) else $error("short glyph address");
    a_col_limit: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        s_q.col < 5'(`CGA_VISIBLE)) else $error("column past twenty");
    a_one_common: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        $onehot0(COM_SEL)) else $error("more than one common selected");
    a_row_limit: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        s_q.row <= last_row || $past(tall) != tall) else $error("row past glyph height");

    // ------------------------------------------------------------
    // pixel and drive checks
    // ------------------------------------------------------------
    sequence s_emit_cell;
        s_q.scan == cga_pkg::CGA_EMIT;
    endsequence

    sequence s_row_end;
        s_q.scan == cga_pkg::CGA_EMIT && s_q.col == 5'(`CGA_VISIBLE - 1);
    endsequence

    a_user_pixels: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        s_emit_cell ##0 (s_q.code[7:4] == 4'h0 && s_q.address_pointer != ref_addr)
        |-> pix == gl_row) else $error("user glyph row not shown");

    a_font_blank: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        s_emit_cell ##0 (s_q.code[7:4] != 4'h0 && s_q.address_pointer != ref_addr)
        |-> pix == 5'h00) else $error("font cell not blank");

    a_cursor_row: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        s_emit_cell ##0 (s_q.address_pointer == ref_addr && s_q.ctrl[`CGA_CTRL_CURSOR]
        && s_q.row == last_row) |-> pix == 5'h1F) else $error("cursor row not lit");

    a_blink_cell: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        s_emit_cell ##0 (s_q.address_pointer == ref_addr && s_q.ctrl[`CGA_CTRL_BLINK]
        && s_q.blink_ph) |-> pix == 5'h1F) else $error("blink cell not lit");

    a_blink_rate: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        s_q.blink_cnt == 32'(BLINK_CYC - 1) |=> s_q.blink_ph != $past(s_q.blink_ph)
        && s_q.blink_cnt == 32'h0000_0000) else $error("blink phase not toggled");

    a_seg_steady: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        !(s_q.scan == cga_pkg::CGA_EMIT && s_q.col == 5'(`CGA_VISIBLE - 1))
        |=> $stable(SEG_OUT) && $stable(COM_SEL)) else $error("drive changed mid row");

    a_com_driven: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        s_row_end |=> COM_SEL != 16'h0000) else $error("no common after row");

    a_row_resync: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        s_q.row > last_row |=> s_q.row == 4'h0) else $error("row not resynchronised");

    a_idle_rdat: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        !WB_ACK_O |-> WB_DAT_O == 32'h0000_0000) else $error("read data outside ack");

endmodule

/* File: cga_host.sv */
/*
 * Host model: classic Wishbone master that writes commands and data.
 * Assumes the slave acks every request; hung rises if it never does.
 */
`timescale 1ns/1ps
module cga_host (
    input wire logic clk,
    output logic cyc = 1'b0,
    output logic stb = 1'b0,
    output logic we = 1'b0,
    output logic [5:0] adr = 6'h00,
    output logic [31:0] dat = 32'h0,
    output logic [3:0] sel = 4'h0,
    input wire logic [31:0] dat_i,
    input wire logic ack,
    output logic hung = 1'b0
);
    // ------------------------------------------------------------
    // one classic cycle, released at the edge that sees ack or after 100 cycles without it
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        do
        begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 100);
        if (ack !== 1'b1)
            hung <= 1'b1;
        q = dat_i;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
endmodule

/* File: cga_char_glyph_test.sv */
/*
 * Self-checking bench: registers, glyph and text fill, scan rows compared.
 * Assumes cga_host as the bus master and a short blink count.
 */
`timescale 1ns/1ps
module cga_char_glyph_test;
    logic SYS_CLK = 1'b0;
    logic NRST = 1'b0;
    logic cyc, stb, we, ack, hung;
    logic [5:0] adr;
    logic [31:0] dat, rdat, q;
    logic [3:0] sel;
    logic [15:0] COM_SEL;
    logic [99:0] SEG_OUT;
    logic [7:0] text [128];
    logic [4:0] glyph [64];
    logic [3:0] ctrl;
    logic [6:0] ptr;
    int n_errors = 0;
    int check_count = 0;
    int seed = 11429;
    int r;
    int lit;
    logic [3:0] ctrl_set [4] = '{4'h4, 4'h6, 4'h5, 4'h8};
    always #20 SYS_CLK = ~SYS_CLK;
    cga_host host (.clk(SYS_CLK), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .dat(dat),
        .sel(sel), .dat_i(rdat), .ack(ack), .hung(hung));
    cga_char_glyph #(.BLINK_CYC(16)) dut (.SYS_CLK(SYS_CLK), .NRST(NRST), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_SEL_I(sel),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .COM_SEL(COM_SEL), .SEG_OUT(SEG_OUT));
    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [99:0] got, input logic [99:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic summarize();
        if (n_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge hung)
    begin
        n_errors++;
        summarize();
    end
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, {24'h0, d}, q);
    endtask
    task automatic rd(input string nm, input logic [5:0] a, input logic [7:0] e);
        host.xfer(1'b0, a, 32'h0, q);
        chk(nm, 100'(q), {92'h0, e});
    endtask
    // ------------------------------------------------------------
    // expected scan row of one line
    // ------------------------------------------------------------
    function automatic logic [99:0] exp_row(input logic [3:0] row, input logic [6:0] base);
        logic [99:0] s;
        logic [7:0] c;
        logic [4:0] p;
        logic [6:0] a;
        s = '0;
        for (int k = 0; k < 20; k++)
        begin
            a = base + 7'(k);
            c = text[a];
            p = (c[7:4] == 4'h0) ? glyph[ctrl[1] ? {c[2:1], row} : {c[2:0], row[2:0]}] : 5'h00;
            if (ctrl[2] && row == (ctrl[1] ? 4'hA : 4'h7) && a == ptr)
                p = p | 5'h1F;
            s[99 - 5 * k -: 5] = p;
        end
        return s;
    endfunction
    task automatic wait_com(input logic [15:0] v, input logic eq);
        int n;
        n = 0;
        while ((COM_SEL === v) != eq && n < 3000)
        begin
            @(posedge SYS_CLK);
            n++;
        end
        if (n == 3000)
        begin
            n_errors++;
            summarize();
        end
    endtask
    task automatic frame(input logic [6:0] base, input int off);
        logic [15:0] t;
        logic [99:0] e;
        logic [99:0] alt;
        // the row latched first may mix settings from before the setup writes
        wait_com(COM_SEL, 1'b0);
        for (int row = 0; row < (ctrl[1] ? 11 : 8); row++)
        begin
            t = 16'h1 << (row + off);
            wait_com(t, 1'b0);
            wait_com(t, 1'b1);
            repeat (2) @(posedge SYS_CLK);
            e = exp_row(4'(row), base);
            alt = e;
            if (ctrl[3] && ptr >= base && ptr < base + 7'h14)
                alt[99 - 5 * int'(ptr - base) -: 5] = 5'h1F;
            // blink phase drifts against the scan: either picture is legal
            if (alt !== e && SEG_OUT === alt)
            begin
                lit++;
                e = alt;
            end
            chk("seg", SEG_OUT, e);
            chk("com", 100'(COM_SEL), 100'(t));
        end
    endtask
    initial
    begin
        repeat (3) @(posedge SYS_CLK);
        chk("reset_seg", SEG_OUT, '0);
        chk("reset_com", 100'(COM_SEL), '0);
        chk("reset_ack", 100'(ack), '0);
        NRST <= 1'b1;
        rd("ctrl", 6'h00, 8'h00);
        wr(6'h3C, 8'hFF);
        rd("unmapped", 6'h3C, 8'h00);
        rd("ctrl_kept", 6'h00, 8'h00);
        r = $random(seed);
        wr(6'h00, 8'(r[3:0]));
        rd("ctrl_rw", 6'h00, {4'h0, r[3:0]});
        wr(6'h04, 8'h00);
        for (int i = 0; i < 64; i++)
        begin
            r = $random(seed);
            // last glyph rows kept clear by the host
            glyph[i] = (i % 8 == 7 || i % 16 == 10) ? 5'h00 : r[4:0];
            wr(6'h0C, {3'h0, glyph[i]});
        end
        wr(6'h04, 8'h80);
        for (int i = 0; i < 128; i++)
        begin
            r = $random(seed);
            text[i] = {r[5:4] == 2'b11 ? 4'h4 : 4'h0, r[3:0]};
            if (i < 4)
                text[i] = {4'h0, i[1], 2'b00, i[0]};
            wr(6'h08, text[i]);
        end
        foreach (ctrl_set[m])
        begin
            ctrl = ctrl_set[m];
            wr(6'h00, {4'h0, ctrl});
            r = $random(seed);
            ptr = {ctrl[0], 6'h00} + 7'(r[7:0] % 20);
            wr(6'h04, {1'b1, ptr});
            rd("pointer", 6'h04, {1'b1, ptr});
            lit = 0;
            frame(7'h00, 0);
            if (ctrl[0])
                frame(7'h40, 8);
            if (ctrl[3])
                chk("blink", 100'(lit > 0 && lit < 8), 100'h1);
        end
        summarize();
    end
endmodule
